/* File: sim/ext_master.sv */
// Behavioural outside bus master that drives the open-drain pins.
`default_nettype none

module ext_master (
	input  wire logic i_clk,     // Bench clock that paces the link.
	output var logic  o_scl_low, // High while this master pulls SCL low.
	output var logic  o_sda_low  // High while this master pulls SDA low.
);
	timeunit 1ns;
	timeprecision 1ps;

	// Both lines are released at power-up; the pull-ups hold them high.
	initial
	begin
		o_scl_low = 1'b0;
		o_sda_low = 1'b0;
	end

	// Waits a number of bench cycles; eight make half a 64 ns link period.
	task automatic pause(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// Start: SDA falls with SCL high, then SCL falls. Never sent mid-frame.
	task automatic send_start();
		o_sda_low <= 1'b1;
		pause(8);
		o_scl_low <= 1'b1;
		pause(8);
	endtask

	// One bit: data changes while SCL is low, SCL high half a period, then low.
	task automatic send_bit(input logic b);
		pause(4);
		o_sda_low <= !b;
		pause(4);
		o_scl_low <= 1'b0;
		pause(8);
		o_scl_low <= 1'b1;
	endtask

	// Stop: SDA low, SCL released, then SDA rises with SCL high.
	task automatic send_stop();
		pause(4);
		o_sda_low <= 1'b1;
		pause(4);
		o_scl_low <= 1'b0;
		pause(8);
		o_sda_low <= 1'b0;
		pause(8);
	endtask
endmodule

`default_nettype wire

/* File: sim/serial_assertions.sv */
// Port-level checker for the two-wire control block.
`default_nettype none

module serial_assertions (
	input wire logic       i_clk,
	input wire logic       i_reset,
	input wire logic [2:0] i_serial_mode_select,
	input wire logic       i_two_wire_mode_select,
	input wire logic [7:0] i_baud_divisor,
	input wire logic       i_start_request,
	input wire logic       i_stop_request,
	input wire logic       i_condition_output_select,
	input wire logic       i_scl,
	input wire logic       o_scl_oe,
	input wire logic       o_sda_oe,
	input wire logic       o_mode_sync,
	input wire logic       o_mode_uart,
	input wire logic [3:0] o_char_bits,
	input wire logic       o_divisor_invalid,
	input wire logic       o_condition_irq,
	input wire logic       o_start_detected,
	input wire logic       o_stop_detected,
	input wire logic       o_bus_busy
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Released-high SCL cycle counter.
	// ------------------------------------------------------------
	logic [3:0] high_r;   // Saturating count of cycles with SCL free and high.
	logic [3:0] high_nxt; // Next value of the count.

	// Counts while SCL is released and high, clears when it is pulled.
	always_comb
	begin
		high_nxt = 4'h0;
		if (!o_scl_oe && i_scl)
			high_nxt = (high_r == 4'hF) ? 4'hF : high_r + 4'h1;
	end

	// Registers the count.
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			high_r <= 4'h0;
		else
			high_r <= high_nxt;
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);

	// ------------------------------------------------------------
	// Properties.
	// ------------------------------------------------------------
	// The generator pulls SDA low for a start at the smallest divisor.
	sequence start_launch_s;
		$rose(o_sda_oe) && !o_scl_oe && i_start_request && i_condition_output_select && i_baud_divisor == 8'h03;
	endsequence
	// SCL then stays free for the rest of a half period and is pulled.
	sequence start_hold_s;
		!o_scl_oe [*3] ##1 o_scl_oe;
	endsequence

	start_hold_a: assert property (start_launch_s |=> start_hold_s)
		else $error("Start hold time is not half a period.");
	stop_setup_a: assert property ($fell(o_sda_oe) && i_stop_request && i_condition_output_select |->
		!o_scl_oe && high_r >= 4'h3) else $error("Stop setup time too short.");
	uart7_len_a: assert property (i_serial_mode_select == serial_pkg::MODE_UART7 |=>
		o_mode_uart && o_char_bits == serial_pkg::CHAR_7) else $error("Seven-bit mode misdecoded.");
	sync_mode_a: assert property (i_serial_mode_select == serial_pkg::MODE_SYNC |=>
		o_mode_sync && !o_mode_uart) else $error("Synchronous mode misdecoded.");
	div_invalid_a: assert property (i_two_wire_mode_select |=>
		o_divisor_invalid == ($past(i_baud_divisor) < serial_pkg::DIV_MIN)) else $error("Divisor flag wrong.");
	detect_irq_a: assert property (o_start_detected && !i_condition_output_select |-> o_condition_irq)
		else $error("Detected start raised no request.");
	busy_set_a: assert property (o_start_detected |-> o_bus_busy)
		else $error("Start did not mark the bus busy.");
	busy_clear_a: assert property (o_stop_detected |-> !o_bus_busy)
		else $error("Stop did not free the bus.");
	quiet_off_a: assert property (!i_two_wire_mode_select |=> !o_start_detected && !o_stop_detected)
		else $error("Condition seen outside two-wire mode.");
endmodule

bind twowire_ctrl serial_assertions u_chk (.*);

`default_nettype wire

/* File: sim/twowire_ctrl_tb.sv */
// Self-checking bench for the two-wire control block.
`default_nettype none

module twowire_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Stimulus, pins and observed outputs.
	// ------------------------------------------------------------
	logic       i_clk = 1'b0;               // 250 MHz count source.
	logic       i_reset = 1'b1;             // Held for 20 cycles.
	logic [2:0] mode = 3'h0;                // Mode field.
	logic       tx_en = 1'b0;               // Transmit enable.
	logic       rx_en = 1'b0;               // Receive enable.
	logic       two_wire = 1'b0;            // Two-wire mode.
	logic       clk_src = 1'b0;             // 0 master, 1 slave.
	logic [7:0] divisor = 8'h03;            // Baud divisor.
	logic       start_req = 1'b0;           // Start request.
	logic       stop_req = 1'b0;            // Stop request.
	logic       sel = 1'b0;                 // Generator drives pins.
	logic       ack_bit = 1'b1;             // Ack level.
	logic       ack_ctl = 1'b0;             // Ack drive enable.
	logic       hold9 = 1'b0;               // Ninth-bit clock hold.
	logic [1:0] shift = 2'h0;               // Shift circuit pulls {SCL, SDA}.
	logic       scl_oe, sda_oe, msync, muart, div_bad, irq, sdet, pdet, busy, cbusy; // Design flags.
	logic [3:0] char_bits;                  // Character length.
	logic       peer_scl, peer_sda;         // Outside master pulls.
	wire        scl_w = !(scl_oe || peer_scl); // Pulled-up SCL wire.
	wire        sda_w = !(sda_oe || peer_sda); // Pulled-up SDA wire.
	int         errors = 0;                 // Mismatches.
	int         num_checks = 0;             // Comparisons made.
	logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7}; // Mode codes, last one unused.
	logic [5:0] exp_mode [6] = '{{2'b00, serial_pkg::CHAR_NONE}, {2'b10, serial_pkg::CHAR_8},
		{2'b01, serial_pkg::CHAR_7}, {2'b01, serial_pkg::CHAR_8}, {2'b01, serial_pkg::CHAR_9},
		{2'b00, serial_pkg::CHAR_NONE}}; // Expected {sync, uart, length}.

	// Free-running clock.
	always #2 i_clk = ~i_clk;

	twowire_ctrl u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_serial_mode_select(mode), .i_tx_enable(tx_en),
		.i_rx_enable(rx_en), .i_two_wire_mode_select(two_wire), .i_clock_source_select(clk_src),
		.i_baud_divisor(divisor), .i_start_request(start_req), .i_repeated_start_request(1'b0),
		.i_stop_request(stop_req), .i_condition_output_select(sel), .i_release_clock_on_stop(1'b0),
		.i_ack_data_bit(ack_bit), .i_ack_output_control(ack_ctl), .i_ninth_bit_clock_hold(hold9),
		.i_shift_scl_low(shift[1]), .i_shift_sda_low(shift[0]), .i_scl(scl_w), .i_sda(sda_w), .o_scl_out(),
		.o_scl_oe(scl_oe), .o_sda_out(), .o_sda_oe(sda_oe), .o_mode_sync(msync), .o_mode_uart(muart),
		.o_char_bits(char_bits), .o_divisor_invalid(div_bad), .o_condition_irq(irq),
		.o_start_detected(sdet), .o_stop_detected(pdet), .o_bus_busy(busy), .o_condition_busy(cbusy));

	ext_master u_peer (.i_clk(i_clk), .o_scl_low(peer_scl), .o_sda_low(peer_sda));

	// ------------------------------------------------------------
	// Shared tasks.
	// ------------------------------------------------------------
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Compares a seen value with the expected one.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t %s: saw %h, expected %h", $time, what, seen, exp);
		end
	endtask

	// Selects an event: start, stop, request, SDA pull, SCL pull.
	function automatic logic ev(input int k);
		return (k == 0) ? sdet : (k == 1) ? pdet : (k == 2) ? irq : (k == 3) ? sda_oe : scl_oe;
	endfunction

	// Waits at falling edges for an event, giving up after 400 cycles.
	task automatic wait_ev(input int k);
		int n;
		n = 0;
		do
		begin
			@(negedge i_clk);
			n++;
		end
		while (n < 400 && ev(k) !== 1'b1);
		if (ev(k) !== 1'b1)
		begin
			errors++;
			$display("[ERR] %0t event %0d never came", $time, k);
			stop_test();
		end
	endtask

	// ------------------------------------------------------------
	// Test sequence.
	// ------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge i_clk);
		i_reset <= 1'b0;
		// Each mode is entered through the disable and re-enable sequence.
		for (int j = 0; j < 6; j++)
		begin
			@(posedge i_clk);
			{tx_en, rx_en} <= 2'b00;
			mode <= serial_pkg::MODE_DISABLED;
			@(posedge i_clk);
			mode <= codes[j];
			@(posedge i_clk);
			{tx_en, rx_en} <= 2'b11;
			@(posedge i_clk);
			@(negedge i_clk);
			chk({msync, muart, char_bits}, exp_mode[j], "mode decode");
		end
		$display("test mode decode done");
		// With the generator off, the pins follow the shift circuit.
		@(posedge i_clk);
		shift <= 2'h3;
		@(negedge i_clk);
		chk({scl_oe, sda_oe}, 2'h3, "shift pulls pins");
		@(posedge i_clk);
		shift <= 2'h0;
		@(negedge i_clk);
		chk({scl_oe, sda_oe}, 2'h0, "shift releases pins");
		@(posedge i_clk);
		mode <= serial_pkg::MODE_UART8;
		two_wire <= 1'b1;
		// Divisors at and below the limit.
		for (int d = 0; d < 4; d++)
		begin
			@(posedge i_clk);
			divisor <= 8'(d);
			repeat (2) @(posedge i_clk);
			@(negedge i_clk);
			chk(div_bad, d < 3, "divisor flag");
		end
		$display("test divisor done");
		// Master generates a start and then a stop.
		@(posedge i_clk);
		start_req <= 1'b1;
		@(posedge i_clk);
		sel <= 1'b1;
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
		chk(cbusy, 1'b1, "generator busy during start hold");
		wait_ev(2);
		chk({scl_oe, sda_oe}, 2'b11, "start drives both lines");
		@(posedge i_clk);
		start_req <= 1'b0;
		stop_req <= 1'b1;
		wait_ev(2);
		chk({scl_oe, sda_oe}, 2'b00, "stop frees both lines");
		@(posedge i_clk);
		stop_req <= 1'b0;
		sel <= 1'b0;
		$display("test generator done");
		// Slave sees a start, acks the eighth bit and holds after the ninth.
		@(posedge i_clk);
		clk_src <= 1'b1;
		{ack_ctl, ack_bit, hold9} <= 3'b101;
		fork
			u_peer.send_start();
			begin
				wait_ev(0);
				chk({irq, busy}, 2'b11, "start detected");
			end
		join
		for (int b = 0; b < 8; b++)
			u_peer.send_bit(1'b1);
		wait_ev(3);
		chk(sda_oe, 1'b1, "ack driven");
		u_peer.send_bit(1'b1);
		wait_ev(4);
		chk(scl_oe, 1'b1, "ninth bit hold");
		@(posedge i_clk);
		hold9 <= 1'b0;
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
		chk(scl_oe, 1'b0, "hold released");
		fork
			u_peer.send_stop();
			begin
				wait_ev(1);
				chk({irq, busy}, 2'b10, "stop detected");
			end
		join
		$display("test slave done");
		stop_test();
	end
endmodule

`default_nettype wire

/* File: src/baud_if.sv */
// Carrier between the controller and its baud tick generator.
`default_nettype none

interface baud_if;
	logic [serial_pkg::DIV_WIDTH-1:0] divisor; // Terminal count of the divider.
	logic                             run;     // Counts while high, preloads one while low.
	logic                             tick;    // One-cycle pulse each divisor+1 cycles.

	modport gen  (input divisor, input run, output tick);
	modport user (output divisor, output run, input tick);
endinterface

`default_nettype wire

/* File: src/baud_tick_gen.sv */
// Baud divider that marks each half SCL period of the count source.
`default_nettype none

module baud_tick_gen (
	input  wire logic i_clk,
	input  wire logic i_reset,
	baud_if.gen       bus
);

	// ------------------------------------------------------------
	// State.
	// ------------------------------------------------------------
	typedef struct packed {
		logic [serial_pkg::DIV_WIDTH-1:0] cnt; // Count-source cycles in this period.
		logic                             tick; // Registered period marker.
	} baud_state_t;

	baud_state_t st_r;  // Current state.
	baud_state_t st_nxt; // Next state.

	// Period is divisor+1 cycles, so a half SCL period is one tick.
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (!bus.run)
		begin
			// Preload one: the registered tick costs a cycle, so the first phase still lasts divisor+1 cycles.
			st_nxt.cnt = '0;
			st_nxt.cnt[0] = 1'b1;
		end
		else if (st_r.cnt == bus.divisor)
		begin
			st_nxt.cnt = '0;
			st_nxt.tick = 1'b1;
		end
		else
		begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
	end

	// Register the state.
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign bus.tick = st_r.tick;

endmodule

`default_nettype wire

/* File: src/serial_pkg.sv */
// Shared constants and types for the two-wire serial control block.
//
// Notes on behaviour
// R1: Software disables, sets mode disabled, re-enables after errors.
// R2: Mode field selects sync, UART7, UART8, UART9, off.
// R3: Condition bits set only after two-wire mode.
// R4: Condition bits master-only; ack bits slave-only.
// R5: Software sets request bit before output select.
// R6: Software programs divisor three or greater.
// R7: Software selects delayed clock in two-wire mode.
// R8: Start hold and stop setup last half period.
// R9: Software accounts for SDA output delay.
// R10: SCL level needs three samples to recognise.
// R11: Divisor below three is invalid and halts.
// R12: Master avoids repeated start toward slave.
// R13: Slave transmit needs enable and buffered data.
// R14: Slave receive needs both enables and data.
// R15: Special mode two used only as master.
// R16: Detect start and stop, one shared request.
// R17: Output select chooses generation or normal pins.
`default_nettype none

package serial_pkg;

	// ------------------------------------------------------------
	// Mode field encodings.
	// ------------------------------------------------------------
	localparam logic [2:0] MODE_DISABLED = 3'h0; // Interface off.
	localparam logic [2:0] MODE_SYNC     = 3'h1; // Clock-synchronous serial.
	localparam logic [2:0] MODE_UART7    = 3'h4; // UART, 7-bit characters.
	localparam logic [2:0] MODE_UART8    = 3'h5; // UART, 8-bit characters.
	localparam logic [2:0] MODE_UART9    = 3'h6; // UART, 9-bit characters.

	// ------------------------------------------------------------
	// Character lengths reported for each mode.
	// ------------------------------------------------------------
	localparam logic [3:0] CHAR_NONE = 4'h0; // No character framing.
	localparam logic [3:0] CHAR_7    = 4'h7; // Seven data bits.
	localparam logic [3:0] CHAR_8    = 4'h8; // Eight data bits.
	localparam logic [3:0] CHAR_9    = 4'h9; // Nine data bits.

	// ------------------------------------------------------------
	// Two-wire timing and framing.
	// ------------------------------------------------------------
	localparam int         DIV_WIDTH = 8;     // Width of the baud divisor.
	localparam logic [7:0] DIV_MIN   = 8'h03; // Smallest usable divisor.
	localparam logic [3:0] ACK_FALL  = 4'h8;  // SCL fall that opens the ack bit.
	localparam logic [3:0] NINTH_FALL = 4'h9; // SCL fall that ends the ack bit.

	// Condition generator states.
	typedef enum logic [2:0] {
		GEN_IDLE,
		GEN_HOLD,
		GEN_RS_RELEASE,
		GEN_RS_SETUP,
		GEN_STOP
	} gen_state_t;

endpackage

`default_nettype wire

/* File: src/twowire_ctrl.sv */
// Two-wire mode control: mode decode, condition generation and detection, slave ack.
`default_nettype none

module twowire_ctrl (
	input  wire logic       i_clk,                  // Count-source clock.
	input  wire logic       i_reset,                // Asynchronous, active high.
	input  wire logic [2:0] i_serial_mode_select,   // Operating mode field.
	input  wire logic       i_tx_enable,            // Transmission enabled.
	input  wire logic       i_rx_enable,            // Reception enabled.
	input  wire logic       i_two_wire_mode_select, // Two-wire mode on.
	input  wire logic       i_clock_source_select,  // 0 internal clock (master), 1 external (slave).
	input  wire logic [7:0] i_baud_divisor,         // Half SCL period minus one.
	input  wire logic       i_start_request,        // Generate a start.
	input  wire logic       i_repeated_start_request, // Generate a repeated start.
	input  wire logic       i_stop_request,         // Generate a stop.
	input  wire logic       i_condition_output_select, // 1 pins generate conditions.
	input  wire logic       i_release_clock_on_stop,   // Release SCL when a stop is seen.
	input  wire logic       i_ack_data_bit,         // Ack level to drive.
	input  wire logic       i_ack_output_control,   // Drive the ack bit.
	input  wire logic       i_ninth_bit_clock_hold, // Hold SCL low after the ninth bit.
	input  wire logic       i_shift_scl_low,        // Shift circuit pulls SCL low.
	input  wire logic       i_shift_sda_low,        // Shift circuit pulls SDA low.
	input  wire logic       i_scl,                  // SCL pin level.
	input  wire logic       i_sda,                  // SDA pin level.
	output logic            o_scl_out,              // SCL output level.
	output logic            o_scl_oe,               // High while SCL is driven low.
	output logic            o_sda_out,              // SDA output level.
	output logic            o_sda_oe,               // High while SDA is driven low.
	output logic            o_mode_sync,            // Clock-synchronous mode active.
	output logic            o_mode_uart,            // UART mode active.
	output logic [3:0]      o_char_bits,            // UART character length.
	output logic            o_divisor_invalid,      // Divisor too small in two-wire mode.
	output logic            o_condition_irq,        // Start/stop request pulse.
	output logic            o_start_detected,       // Start seen, one-cycle pulse.
	output logic            o_stop_detected,        // Stop seen, one-cycle pulse.
	output logic            o_bus_busy,             // Between start and stop.
	output logic            o_condition_busy        // Generator in progress.
);

	// ------------------------------------------------------------
	// State.
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0]             scl_s;      // SCL synchroniser chain.
		logic [2:0]             sda_s;      // SDA synchroniser chain.
		logic                   scl_f;      // Accepted SCL level.
		logic                   sda_f;      // Accepted SDA level.
		serial_pkg::gen_state_t gen;        // Condition generator state.
		logic                   gen_scl_low; // Generator pulls SCL low.
		logic                   gen_sda_low; // Generator pulls SDA low.
		logic                   busy;       // Bus busy flag.
		logic [3:0]             falls;      // SCL falls since start.
		logic                   hold;       // Slave ninth-bit clock hold.
		logic                   scl_open;   // SCL released after a foreign stop.
		logic                   irq;        // Condition request pulse.
		logic                   start_det;  // Start detection pulse.
		logic                   stop_det;   // Stop detection pulse.
		logic [3:0]             char_bits;  // Decoded character length.
		logic                   sync_m;     // Decoded sync mode.
		logic                   uart_m;     // Decoded UART mode.
		logic                   div_bad;    // Divisor invalid flag.
	} ctrl_state_t;

	ctrl_state_t st_r;   // Current state.
	ctrl_state_t st_nxt; // Next state.

	// ------------------------------------------------------------
	// Baud tick generator.
	// ------------------------------------------------------------
	baud_if baud ();

	baud_tick_gen u_baud (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.bus     (baud)
	);

	logic tw_on;     // Two-wire operation allowed.
	logic master;    // Internal clock, master operation.
	logic gen_mode;  // Pins under the condition generator.
	logic scl_fall;  // Accepted SCL falling edge.
	logic sda_fall;  // Accepted SDA falling edge.
	logic sda_rise;  // Accepted SDA rising edge.

	// The generator runs the divider only while a condition is in progress.
	assign baud.divisor = i_baud_divisor;
	assign baud.run     = (st_r.gen != serial_pkg::GEN_IDLE);

	// Two-wire logic halts when the mode is off or the divisor would slip bits.
	assign tw_on    = i_two_wire_mode_select && (i_baud_divisor >= serial_pkg::DIV_MIN); // R11
	assign master   = !i_clock_source_select; // R4
	assign gen_mode = tw_on && master && i_condition_output_select; // R17

	// Edges are taken from accepted levels only, never from the first stage.
	assign scl_fall = st_r.scl_f && !st_nxt.scl_f;
	assign sda_fall = st_r.sda_f && !st_nxt.sda_f;
	assign sda_rise = !st_r.sda_f && st_nxt.sda_f;

	// ------------------------------------------------------------
	// Next-state logic.
	// ------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.irq = 1'b0;
		st_nxt.start_det = 1'b0;
		st_nxt.stop_det = 1'b0;

		// Three-stage sampling; a level counts once the last two agree.
		st_nxt.scl_s = {st_r.scl_s[1:0], i_scl}; // R10
		st_nxt.sda_s = {st_r.sda_s[1:0], i_sda};
		if (st_r.scl_s[1] == st_r.scl_s[2])
			st_nxt.scl_f = st_r.scl_s[2]; // R10
		if (st_r.sda_s[1] == st_r.sda_s[2])
			st_nxt.sda_f = st_r.sda_s[2];

		// Mode field decode; unlisted codes read as disabled.
		st_nxt.sync_m = 1'b0;
		st_nxt.uart_m = 1'b0;
		st_nxt.char_bits = serial_pkg::CHAR_NONE;
		case (i_serial_mode_select) // R2
			serial_pkg::MODE_SYNC:
			begin
				st_nxt.sync_m = 1'b1;
				st_nxt.char_bits = serial_pkg::CHAR_8;
			end
			serial_pkg::MODE_UART7:
			begin
				st_nxt.uart_m = 1'b1;
				st_nxt.char_bits = serial_pkg::CHAR_7;
			end
			serial_pkg::MODE_UART8:
			begin
				st_nxt.uart_m = 1'b1;
				st_nxt.char_bits = serial_pkg::CHAR_8;
			end
			serial_pkg::MODE_UART9:
			begin
				st_nxt.uart_m = 1'b1;
				st_nxt.char_bits = serial_pkg::CHAR_9;
			end
			default:
			begin
				st_nxt.char_bits = serial_pkg::CHAR_NONE;
			end
		endcase
		st_nxt.div_bad = i_two_wire_mode_select && (i_baud_divisor < serial_pkg::DIV_MIN); // R11

		// Start and stop detection on SDA edges while SCL is high.
		if (i_two_wire_mode_select && st_nxt.scl_f && st_r.scl_f)
		begin
			if (sda_fall)
			begin
				st_nxt.start_det = 1'b1; // R16
				st_nxt.busy = 1'b1;
				st_nxt.falls = '1; // The start's own SCL fall wraps this to zero; a repeated start restarts it.
				st_nxt.hold = 1'b0;
			end
			else if (sda_rise)
			begin
				st_nxt.stop_det = 1'b1; // R16
				st_nxt.busy = 1'b0;
				st_nxt.hold = 1'b0;
				if (master && i_release_clock_on_stop && !gen_mode)
					st_nxt.scl_open = 1'b1; // R4
			end
		end
		// Detection raises the shared request unless conditions are generated.
		if ((st_nxt.start_det || st_nxt.stop_det) && !gen_mode)
			st_nxt.irq = 1'b1; // R17
		if (!i_release_clock_on_stop || st_nxt.start_det)
			st_nxt.scl_open = 1'b0;

		// Slave ack bit and ninth-bit hold, counted on SCL falls.
		if (st_r.busy && scl_fall && st_r.falls != serial_pkg::NINTH_FALL)
			st_nxt.falls = st_r.falls + 1'b1;
		if (!master && st_nxt.falls == serial_pkg::NINTH_FALL && scl_fall && i_ninth_bit_clock_hold)
			st_nxt.hold = 1'b1; // R4
		if (!i_ninth_bit_clock_hold)
			st_nxt.hold = 1'b0;

		// Condition generator, stepped by half-period ticks.
		case (st_r.gen)
			serial_pkg::GEN_IDLE:
			begin
				if (gen_mode && i_start_request && st_r.scl_f && st_r.sda_f)
				begin
					st_nxt.gen_sda_low = 1'b1; // R8
					st_nxt.gen = serial_pkg::GEN_HOLD;
				end
				else if (gen_mode && i_repeated_start_request)
				begin
					st_nxt.gen_sda_low = 1'b0;
					st_nxt.gen = serial_pkg::GEN_RS_RELEASE;
				end
				else if (gen_mode && i_stop_request)
				begin
					st_nxt.gen_sda_low = 1'b1;
					st_nxt.gen_scl_low = 1'b0;
					st_nxt.gen = serial_pkg::GEN_STOP;
				end
			end
			serial_pkg::GEN_HOLD:
			begin
				// SDA has been low half a period; now SCL falls.
				if (baud.tick)
				begin
					st_nxt.gen_scl_low = 1'b1; // R8
					st_nxt.irq = 1'b1; // R17
					st_nxt.gen = serial_pkg::GEN_IDLE;
				end
			end
			serial_pkg::GEN_RS_RELEASE:
			begin
				if (baud.tick)
				begin
					st_nxt.gen_scl_low = 1'b0;
					st_nxt.gen = serial_pkg::GEN_RS_SETUP;
				end
			end
			serial_pkg::GEN_RS_SETUP:
			begin
				// Wait for SCL really high, so a stretching slave is honoured.
				if (baud.tick && st_r.scl_f)
				begin
					st_nxt.gen_sda_low = 1'b1;
					st_nxt.gen = serial_pkg::GEN_HOLD;
				end
			end
			serial_pkg::GEN_STOP:
			begin
				// SCL has been high half a period; now SDA rises.
				if (baud.tick && st_r.scl_f)
				begin
					st_nxt.gen_sda_low = 1'b0; // R8
					st_nxt.irq = 1'b1; // R17
					st_nxt.gen = serial_pkg::GEN_IDLE;
				end
			end
			default:
			begin
				st_nxt.gen = serial_pkg::GEN_IDLE;
			end
		endcase

		// Leaving generator mode or two-wire mode drops the condition logic.
		if (!gen_mode)
		begin
			st_nxt.gen = serial_pkg::GEN_IDLE;
			st_nxt.gen_scl_low = 1'b0;
			st_nxt.gen_sda_low = 1'b0;
		end
		// Disabling both directions, the mode or two-wire operation clears transfers.
		if (!tw_on || (!i_tx_enable && !i_rx_enable) || i_serial_mode_select == serial_pkg::MODE_DISABLED)
		begin
			st_nxt.busy = 1'b0;
			st_nxt.falls = '0;
			st_nxt.hold = 1'b0;
			st_nxt.scl_open = 1'b0;
			st_nxt.start_det = 1'b0;
			st_nxt.stop_det = 1'b0;
			st_nxt.irq = 1'b0;
			st_nxt.gen = serial_pkg::GEN_IDLE;
			st_nxt.gen_scl_low = 1'b0;
			st_nxt.gen_sda_low = 1'b0;
		end
	end

	// Register the state; pin samplers reset to the idle-high bus.
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			st_r <= '0;
			st_r.scl_s <= 3'h7;
			st_r.sda_s <= 3'h7;
			st_r.scl_f <= 1'b1;
			st_r.sda_f <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Pin drive.
	// ------------------------------------------------------------
	logic ack_drive; // Slave drives the ack bit low.

	// Ack bit window lies between the eighth and ninth SCL falls.
	assign ack_drive = tw_on && !master && i_ack_output_control && !i_ack_data_bit
		&& st_r.falls == serial_pkg::ACK_FALL; // R4

	// Pins carry conditions in generator mode, else normal clock and data.
	assign o_scl_out = 1'b0;
	assign o_sda_out = 1'b0;
	assign o_scl_oe  = gen_mode ? st_r.gen_scl_low
		: ((i_shift_scl_low && !st_r.scl_open) || st_r.hold); // R17
	assign o_sda_oe  = gen_mode ? st_r.gen_sda_low : (i_shift_sda_low || ack_drive); // R17

	// Status outputs, all from registers.
	assign o_mode_sync       = st_r.sync_m;
	assign o_mode_uart       = st_r.uart_m;
	assign o_char_bits       = st_r.char_bits;
	assign o_divisor_invalid = st_r.div_bad;
	assign o_condition_irq   = st_r.irq;
	assign o_start_detected  = st_r.start_det;
	assign o_stop_detected   = st_r.stop_det;
	assign o_bus_busy        = st_r.busy;
	assign o_condition_busy  = (st_r.gen != serial_pkg::GEN_IDLE);

endmodule

`default_nettype wire
